// File: cblu_branch_unit.sv
// branch decode and resolve for the negative likely and unequal branches
`timescale 1ns/1ns

// Summary of operation
// - decode group opcode with selector 00010
// - target is slot address plus sign-extended offset*4
// - negative likely taken when sign bit set
// - unequal forms taken when registers differ
// - redirect only after delay slot executes
// - likely not taken annuls delay slot
// - release 6: control transfer in slot traps
// - control transfers: branches, jumps, returns, wait, pause
// - likely forms reserved on release 6
// - likely predicted taken, tables untouched
// - oldest level: negative likely is reserved
module cblu_branch_unit (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// implementation level straps
	input wire logic release6,
	input wire logic oldest_level,
	// instruction issue from decode
	input wire logic instr_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] instr_pc,
	// general register values read for both register fields
	input wire logic [31:0] source_reg_a_val,
	input wire logic [31:0] source_reg_b_val,
	// branch resolution
	output logic branch_seen_q,
	output logic branch_taken_q,
	output logic [31:0] branch_target_q,
	output logic predict_taken_q,
	output logic predictor_access_q,
	// delay slot outcome
	output logic redirect_q,
	output logic [31:0] redirect_pc_q,
	output logic annul_slot_q,
	output logic reserved_instr_q
);
	import cblu_pkg::*;

	// ==================================================================
	// decode helper

	// map an instruction word to the branch kind it names
	function automatic cblu_kind_t decode_kind(input logic [31:0] w);
		cblu_kind_t k;
		k = CBLU_KIND_NONE;
		if (w[OPC_HI:OPC_LO] == OPC_REG_IMM_GROUP && w[RSB_HI:RSB_LO] == RI_NEG_LIKELY) begin
			k = CBLU_KIND_NEG_LIKELY;
		end else if (w[OPC_HI:OPC_LO] == OPC_BR_UNEQUAL) begin
			k = CBLU_KIND_UNEQUAL;
		end else if (w[OPC_HI:OPC_LO] == OPC_BR_UNEQUAL_LIKELY) begin
			k = CBLU_KIND_UNEQUAL_LIKELY;
		end
		return k;
	endfunction : decode_kind

	// ==================================================================
	// state

	typedef enum logic {
		CBLU_ST_IDLE,
		CBLU_ST_SLOT
	} cblu_state_t;

	cblu_state_t state_q; // idle or waiting for the delay slot
	logic pend_taken_q; // pending branch outcome
	logic pend_likely_q; // pending branch is a likely form
	logic [31:0] pend_target_q; // pending branch target

	// ==================================================================
	// combinational decode of the issuing word

	cblu_kind_t kind; // kind of the issuing word
	logic is_likely; // issuing word is a likely form
	logic reserved_kind; // encoding not provided at this level
	logic cond_true; // branch condition
	logic [31:0] slot_pc; // address of the delay slot
	logic [31:0] offset_ext; // sign-extended, shifted offset
	logic [BROFS_W-1:0] offset_sh; // offset moved up two places
	logic slot_is_cti; // issuing word transfers control

	assign kind = decode_kind(instr);
	assign is_likely = (kind == CBLU_KIND_NEG_LIKELY) || (kind == CBLU_KIND_UNEQUAL_LIKELY);

	// likely forms absent on release 6; oldest level lacks negative likely
	assign reserved_kind = (is_likely && release6) ||
		(kind == CBLU_KIND_NEG_LIKELY && oldest_level);

	// condition per kind
	always_comb begin
		cond_true = 1'b0;
		unique case (kind)
			CBLU_KIND_NEG_LIKELY: begin
				cond_true = source_reg_a_val[SIGN_BIT];
			end
			CBLU_KIND_UNEQUAL, CBLU_KIND_UNEQUAL_LIKELY: begin
				cond_true = (source_reg_a_val != source_reg_b_val);
			end
			CBLU_KIND_NONE: begin
				cond_true = 1'b0;
			end
		endcase
	end

	// offset is relative to the slot, not the branch itself
	assign slot_pc = instr_pc + INSTR_BYTES;
	assign offset_sh = {instr[OFS_HI:OFS_LO], {SHIFT_W{1'b0}}};
	assign offset_ext = {{(WORD_W-BROFS_W){offset_sh[BROFS_W-1]}}, offset_sh};

	// the same classifier serves every slot word
	cblu_cti_class u_cti (
		.instr(instr),
		.is_cti(slot_is_cti)
	);

	// ==================================================================
	// slot tracking; the word after an accepted branch is its delay slot

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= CBLU_ST_IDLE;
		end else if (ce && instr_valid) begin
			unique case (state_q)
				CBLU_ST_IDLE: begin
					// a reserved encoding traps and opens no slot
					if (kind != CBLU_KIND_NONE && !reserved_kind) begin
						state_q <= CBLU_ST_SLOT;
					end
				end
				CBLU_ST_SLOT: begin
					// a branch in the slot is not started again; old levels leave it undefined
					state_q <= CBLU_ST_IDLE;
				end
			endcase
		end
	end

	// capture the outcome when the branch issues
	always_ff @(posedge clk) begin
		if (rst) begin
			pend_taken_q <= 1'b0;
			pend_likely_q <= 1'b0;
			pend_target_q <= 32'h0000_0000;
		end else if (ce && instr_valid && state_q == CBLU_ST_IDLE && kind != CBLU_KIND_NONE) begin
			pend_taken_q <= cond_true;
			pend_likely_q <= is_likely;
			pend_target_q <= slot_pc + offset_ext;
		end
	end

	// ==================================================================
	// resolution pulses at branch issue

	always_ff @(posedge clk) begin
		if (rst) begin
			branch_seen_q <= 1'b0;
			branch_taken_q <= 1'b0;
			branch_target_q <= 32'h0000_0000;
			predict_taken_q <= 1'b0;
			predictor_access_q <= 1'b0;
		end else if (ce) begin
			// one pulse per accepted branch outside a slot
			branch_seen_q <= instr_valid && state_q == CBLU_ST_IDLE &&
				kind != CBLU_KIND_NONE && !reserved_kind;
			branch_taken_q <= cond_true;
			branch_target_q <= slot_pc + offset_ext;
			// likely forms: static taken, tables bypassed
			predict_taken_q <= instr_valid && state_q == CBLU_ST_IDLE && is_likely;
			predictor_access_q <= instr_valid && state_q == CBLU_ST_IDLE &&
				kind == CBLU_KIND_UNEQUAL;
		end
	end

	// ==================================================================
	// delay slot outcome; trap wins over redirect so the handler can retry

	always_ff @(posedge clk) begin
		if (rst) begin
			redirect_q <= 1'b0;
			redirect_pc_q <= 32'h0000_0000;
			annul_slot_q <= 1'b0;
			reserved_instr_q <= 1'b0;
		end else if (ce) begin
			redirect_q <= 1'b0;
			annul_slot_q <= 1'b0;
			reserved_instr_q <= 1'b0;
			if (instr_valid && state_q == CBLU_ST_IDLE) begin
				// reserved likely encodings trap at issue
				reserved_instr_q <= reserved_kind;
			end else if (instr_valid && state_q == CBLU_ST_SLOT) begin
				if (release6 && slot_is_cti) begin
					reserved_instr_q <= 1'b1;
				end else if (pend_likely_q && !pend_taken_q) begin
					annul_slot_q <= 1'b1;
				end else if (pend_taken_q) begin
					// jump only once the slot word has gone through
					redirect_q <= 1'b1;
				end
				redirect_pc_q <= pend_target_q;
			end
		end
	end

endmodule : cblu_branch_unit

// File: cblu_pkg.sv
// constants and types for the conditional branch likely unit
package cblu_pkg;

	// ==================================================================
	// instruction field positions
	localparam int OPC_HI = 31;
	localparam int OPC_LO = 26;
	localparam int RSA_HI = 25;
	localparam int RSA_LO = 21;
	localparam int RSB_HI = 20;
	localparam int RSB_LO = 16;
	localparam int OFS_HI = 15;
	localparam int OFS_LO = 0;
	localparam int FUNCT_HI = 5;
	localparam int FUNCT_LO = 0;
	localparam int SIGN_BIT = 31;
	localparam int EXCEPTION_RETURN_NO_CLEAR_BIT = 6;
	localparam int COP_CO_BIT = 25;

	// ==================================================================
	// widths
	localparam int WORD_W = 32;
	localparam int OFS_W = 16;
	localparam int SHIFT_W = 2;
	localparam int BROFS_W = 18;

	// ==================================================================
	// primary opcodes
	localparam logic [5:0] OPC_SPECIAL = 6'h00;
	localparam logic [5:0] OPC_REG_IMM_GROUP = 6'h01; // register_immediate_group_opcode
	localparam logic [5:0] OPC_JUMP = 6'h02;
	localparam logic [5:0] OPC_JUMP_LINK = 6'h03;
	localparam logic [5:0] OPC_BR_EQUAL = 6'h04;
	localparam logic [5:0] OPC_BR_UNEQUAL = 6'h05;
	localparam logic [5:0] OPC_BR_LEZ = 6'h06;
	localparam logic [5:0] OPC_BR_GTZ = 6'h07;
	localparam logic [5:0] OPC_POP10 = 6'h08;
	localparam logic [5:0] OPC_COP0 = 6'h10;
	localparam logic [5:0] OPC_COP1 = 6'h11;
	localparam logic [5:0] OPC_BR_EQUAL_LIKELY = 6'h14;
	localparam logic [5:0] OPC_BR_UNEQUAL_LIKELY = 6'h15;
	localparam logic [5:0] OPC_BR_LEZ_LIKELY = 6'h16;
	localparam logic [5:0] OPC_BR_GTZ_LIKELY = 6'h17;
	localparam logic [5:0] OPC_POP30 = 6'h18;
	localparam logic [5:0] OPC_COMPACT_BR = 6'h32;
	localparam logic [5:0] OPC_COMPACT_BEQZ = 6'h36;
	localparam logic [5:0] OPC_COMPACT_BAL = 6'h3a;
	localparam logic [5:0] OPC_COMPACT_BNEZ = 6'h3e;

	// ==================================================================
	// secondary codes
	localparam logic [4:0] RI_NEG_LIKELY = 5'h02; // branch_negative_likely selector
	localparam logic [4:0] RI_BRANCH_MASK = 5'h0c; // selectors 0x00..0x03, 0x10..0x13
	localparam logic [4:0] COP1_BRANCH_RS = 5'h08;
	localparam logic [5:0] FN_JUMP_REG = 6'h08;
	localparam logic [5:0] FN_JUMP_REG_LINK = 6'h09;
	localparam logic [5:0] FN_EXC_RETURN = 6'h18;
	localparam logic [5:0] FN_DBG_RETURN = 6'h1f;
	localparam logic [5:0] FN_WAIT = 6'h20;
	localparam logic [31:0] PAUSE_WORD = 32'h0000_0140;

	// ==================================================================
	// address step to the delay slot
	localparam logic [31:0] INSTR_BYTES = 32'h0000_0004;

	// branch kinds handled by this unit
	typedef enum logic [1:0] {
		CBLU_KIND_NONE,
		CBLU_KIND_NEG_LIKELY,
		CBLU_KIND_UNEQUAL,
		CBLU_KIND_UNEQUAL_LIKELY
	} cblu_kind_t;

endpackage : cblu_pkg

// File: cblu_cti_class.sv
// classifier flagging control-transfer instructions
`timescale 1ns/1ns

module cblu_cti_class (
	// instruction word under test
	input wire logic [31:0] instr,
	// high when the word transfers control
	output logic is_cti
);
	import cblu_pkg::*;

	logic [5:0] opc; // primary opcode
	logic [5:0] fn; // function field
	logic [4:0] sel_b; // second register field, selector under the group opcode
	logic [4:0] sel_a; // first register field

	assign opc = instr[OPC_HI:OPC_LO];
	assign fn = instr[FUNCT_HI:FUNCT_LO];
	assign sel_b = instr[RSB_HI:RSB_LO];
	assign sel_a = instr[RSA_HI:RSA_LO];

	// ==================================================================
	// opcode classification; exception returns match with or without clear
	always_comb begin
		is_cti = 1'b0;
		unique case (opc)
			OPC_JUMP, OPC_JUMP_LINK, OPC_BR_EQUAL, OPC_BR_UNEQUAL, OPC_BR_LEZ, OPC_BR_GTZ,
			OPC_BR_EQUAL_LIKELY, OPC_BR_UNEQUAL_LIKELY, OPC_BR_LEZ_LIKELY, OPC_BR_GTZ_LIKELY,
			OPC_POP10, OPC_POP30, OPC_COMPACT_BR, OPC_COMPACT_BEQZ, OPC_COMPACT_BAL,
			OPC_COMPACT_BNEZ: begin
				is_cti = 1'b1; // branches and jumps
			end
			OPC_REG_IMM_GROUP: begin
				// conditional forms incl. no_op_and_link
				is_cti = ((sel_b & RI_BRANCH_MASK) == 5'h00);
			end
			OPC_SPECIAL: begin
				// register jumps, wait-free pause
				is_cti = (fn == FN_JUMP_REG) || (fn == FN_JUMP_REG_LINK) || (instr == PAUSE_WORD);
			end
			OPC_COP0: begin
				// exception_return, exception_return_no_clear, debug return, wait
				is_cti = instr[COP_CO_BIT] &&
					((fn == FN_EXC_RETURN) || (fn == FN_DBG_RETURN) || (fn == FN_WAIT));
			end
			OPC_COP1: begin
				is_cti = (sel_a == COP1_BRANCH_RS); // floating condition branches
			end
			default: begin
				is_cti = 1'b0;
			end
		endcase
	end

endmodule : cblu_cti_class

// File: cblu_sva.sv
// assertion checker watching the branch unit ports
`timescale 1ns/1ns
module cblu_sva
	import cblu_pkg::*;
(
	// clock, reset, straps
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic release6,
	input wire logic oldest_level,
	// issue side
	input wire logic instr_valid,
	input wire logic [31:0] instr,
	input wire logic [31:0] instr_pc,
	input wire logic [31:0] source_reg_a_val,
	input wire logic [31:0] source_reg_b_val,
	// resolution side
	input wire logic branch_seen_q,
	input wire logic branch_taken_q,
	input wire logic [31:0] branch_target_q,
	input wire logic predict_taken_q,
	input wire logic predictor_access_q,
	input wire logic redirect_q,
	input wire logic [31:0] redirect_pc_q,
	input wire logic annul_slot_q,
	input wire logic reserved_instr_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// slot still owed after idle cycles
	logic pend_q;
	wire take = ce && instr_valid;
	wire in_slot = pend_q || branch_seen_q;
	wire head = take && !in_slot;
	wire is_ne = instr[31:26] == OPC_BR_UNEQUAL;
	wire is_nel = instr[31:26] == OPC_BR_UNEQUAL_LIKELY;
	wire is_nl = instr[31:26] == OPC_REG_IMM_GROUP && instr[20:16] == RI_NEG_LIKELY;
	wire [31:0] tgt = instr_pc + 32'h0000_0004 + {{14{instr[15]}}, instr[15:0], 2'b00};
	// slot is consumed by the next accepted word
	always_ff @(posedge clk) begin
		if (rst) pend_q <= 1'b0;
		else if (take) pend_q <= 1'b0;
		else if (branch_seen_q) pend_q <= 1'b1;
	end
	// ==================================================================
	// slot sequences
	sequence s_slot_hit;
		branch_seen_q && branch_taken_q && take && !release6;
	endsequence
	sequence s_slot_miss;
		branch_seen_q && predict_taken_q && !branch_taken_q && take && !release6;
	endsequence
	a_unequal_cond: assert property (head && is_ne
		|=> branch_seen_q && predictor_access_q && !predict_taken_q
		&& branch_taken_q == ($past(source_reg_a_val) != $past(source_reg_b_val)))
		else $error("unequal branch resolved wrongly");
	a_neg_cond: assert property (head && is_nl
		&& !release6 && !oldest_level |=> branch_seen_q && predict_taken_q
		&& !predictor_access_q && branch_taken_q == $past(source_reg_a_val[31]))
		else $error("negative likely resolved wrongly");
	a_target_calc: assert property (head && is_ne |=> branch_target_q == $past(tgt))
		else $error("branch target wrong");
	a_likely_r6: assert property (head && release6 && (is_nel || is_nl)
		|=> reserved_instr_q && !branch_seen_q)
		else $error("likely form not refused");
	a_neg_oldest: assert property (head && oldest_level && is_nl
		|=> reserved_instr_q && !branch_seen_q)
		else $error("negative likely not refused");
	a_no_early: assert property (branch_seen_q |-> !redirect_q && !annul_slot_q)
		else $error("redirect before slot");
	a_redirect_slot: assert property (s_slot_hit |=> redirect_q && !annul_slot_q
		&& redirect_pc_q == $past(branch_target_q)) else $error("slot redirect wrong");
	a_annul_miss: assert property (s_slot_miss |=> annul_slot_q && !redirect_q)
		else $error("missed likely slot not annulled");
	a_slot_trap: assert property (take && in_slot && release6 && is_ne
		|=> reserved_instr_q && !redirect_q)
		else $error("transfer in slot not trapped");
	// a frozen cycle must neither start nor finish a slot
	a_ce_freeze: assert property (!ce
		|=> $stable(branch_seen_q) && $stable(redirect_q) && $stable(annul_slot_q)
		&& $stable(reserved_instr_q) && $stable(redirect_pc_q))
		else $error("outputs moved while enable low");
endmodule : cblu_sva

// File: cblu_fetch_model.sv
// fetch side model issuing words to the branch unit
`timescale 1ns/1ns
module cblu_fetch_model #(
	parameter logic [31:0] START_PC = 32'h0000_1000
) (
	// clock, reset, bench request
	input wire logic clk,
	input wire logic rst,
	input wire logic req,
	input wire logic [31:0] req_word,
	input wire logic [31:0] req_a,
	input wire logic [31:0] req_b,
	// redirect from the unit
	input wire logic redirect_q,
	input wire logic [31:0] redirect_pc_q,
	// issue toward the unit
	output logic instr_valid,
	output logic [31:0] instr,
	output logic [31:0] instr_pc,
	output logic [31:0] source_reg_a_val,
	output logic [31:0] source_reg_b_val
);
	logic [31:0] pc_q;
	// sequential fetch, redirect wins; idle lines invert so no stale word is seen
	always_ff @(posedge clk) begin
		if (rst) begin
			pc_q <= START_PC;
			{instr_valid, instr, instr_pc} <= '0;
		end else begin
			instr_valid <= req;
			instr <= req ? req_word : ~instr; // slot words only as the bench commands
			instr_pc <= req ? pc_q : ~instr_pc;
			source_reg_a_val <= req ? req_a : ~source_reg_a_val;
			source_reg_b_val <= req ? req_b : ~source_reg_b_val;
			pc_q <= redirect_q ? redirect_pc_q : pc_q + (req ? 32'h0000_0004 : 32'h0000_0000);
		end
	end
endmodule : cblu_fetch_model

// File: tb.sv
// self-checking bench for the branch unit
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
	import cblu_pkg::*;
	logic clk = 1'b0, rst = 1'b1, ce = 1'b1, release6 = 1'b0, oldest_level = 1'b0, req = 1'b0;
	logic [31:0] req_word = 32'h0000_0000, req_a = 32'h0000_0000, req_b = 32'h0000_0000;
	logic vld, seen, tk, pred, acc, red, ann, resv;
	logic [31:0] instr, ipc, a_val, b_val, tgt, rpc, bpc, c_tgt, c_rpc;
	logic c_seen, c_tk, c_pred, c_acc, c_res1, c_red, c_ann, c_res2;
	int failures = 0, checks_done = 0;
	initial begin
		forever #50 clk = ~clk;
	end
	cblu_fetch_model fetch (.clk(clk), .rst(rst), .req(req), .req_word(req_word), .req_a(req_a),
		.req_b(req_b), .redirect_q(red), .redirect_pc_q(rpc), .instr_valid(vld), .instr(instr),
		.instr_pc(ipc), .source_reg_a_val(a_val), .source_reg_b_val(b_val));
	cblu_branch_unit dut (.clk(clk), .rst(rst), .ce(ce), .release6(release6),
		.oldest_level(oldest_level), .instr_valid(vld), .instr(instr), .instr_pc(ipc),
		.source_reg_a_val(a_val), .source_reg_b_val(b_val), .branch_seen_q(seen),
		.branch_taken_q(tk), .branch_target_q(tgt), .predict_taken_q(pred),
		.predictor_access_q(acc), .redirect_q(red), .redirect_pc_q(rpc), .annul_slot_q(ann),
		.reserved_instr_q(resv));
	function automatic logic [31:0] bw(logic [5:0] op, logic [4:0] ra, logic [4:0] rb,
		logic [15:0] o);
		return {op, ra, rb, o};
	endfunction : bw
	function automatic logic [31:0] xt(logic [15:0] o);
		return bpc + 32'h0000_0004 + {{14{o[15]}}, o, 2'b00};
	endfunction : xt
	// branch then slot back to back, answers captured a cycle apart
	task automatic run_pair(input logic [31:0] br, sl, a, b);
		@(posedge clk);
		req <= 1'b1;
		{req_word, req_a, req_b} <= {br, a, b};
		@(posedge clk);
		req_word <= sl;
		#1 bpc = ipc;
		@(posedge clk);
		req <= 1'b0;
		@(negedge clk);
		{c_seen, c_tk, c_pred, c_acc, c_res1, c_tgt} = {seen, tk, pred, acc, resv, tgt};
		@(negedge clk);
		{c_red, c_ann, c_res2, c_rpc} = {red, ann, resv, rpc};
		repeat (2) @(posedge clk);
	endtask : run_pair
	task automatic t_unequal();
		run_pair(bw(OPC_BR_UNEQUAL, 5'd1, 5'd2, 16'h8000), '0, 32'h0000_0005, 32'h0000_0006);
		`CHK({c_seen, c_tk, c_pred, c_acc}, 4'b1101)
		`CHK(c_tgt, xt(16'h8000))
		`CHK({c_red, c_ann, c_rpc}, {2'b10, xt(16'h8000)})
		run_pair(bw(OPC_BR_UNEQUAL, 5'd1, 5'd2, 16'h0004), '0, 32'h0000_0007, 32'h0000_0007);
		`CHK({c_seen, c_tk, c_red, c_ann}, 4'b1000)
		$display("t_unequal done");
	endtask : t_unequal
	task automatic t_likely();
		run_pair(bw(OPC_BR_UNEQUAL_LIKELY, 5'd4, 5'd5, 16'h0008), '0, 32'h0000_0009, 32'h0000_0009);
		`CHK({c_seen, c_tk, c_pred, c_acc}, 4'b1010)
		`CHK({c_red, c_ann}, 2'b01)
		run_pair(bw(OPC_BR_UNEQUAL_LIKELY, 5'd4, 5'd5, 16'h7fff), '0, 32'h0000_0009, 32'h0000_0001);
		`CHK({c_tk, c_red, c_ann, c_rpc}, {3'b110, xt(16'h7fff)})
		$display("t_likely done");
	endtask : t_likely
	// sign bit alone decides, both ends of the range
	task automatic t_negative();
		for (int i = 0; i < 2; i++) begin
			run_pair(bw(OPC_REG_IMM_GROUP, 5'd3, RI_NEG_LIKELY, 16'h0010), '0,
				i ? 32'h7fff_ffff : 32'h8000_0000, 32'h0000_0000);
			`CHK({c_seen, c_tk, c_pred, c_acc}, {1'b1, i == 0, 2'b10})
			`CHK({c_red, c_ann}, {i == 0, i != 0})
		end
		$display("t_negative done");
	endtask : t_negative
	task automatic t_reserved();
		release6 <= 1'b1;
		run_pair(bw(OPC_BR_UNEQUAL_LIKELY, 5'd1, 5'd2, 16'h0001), '0, 32'h0000_0001, 32'h0000_0002);
		`CHK({c_seen, c_res1, c_red}, 3'b010)
		run_pair(bw(OPC_REG_IMM_GROUP, 5'd1, RI_NEG_LIKELY, 16'h0001), '0, 32'h8000_0000, '0);
		`CHK({c_seen, c_res1}, 2'b01)
		release6 <= 1'b0;
		oldest_level <= 1'b1;
		run_pair(bw(OPC_REG_IMM_GROUP, 5'd1, RI_NEG_LIKELY, 16'h0001), '0, 32'h8000_0000, '0);
		`CHK({c_seen, c_res1}, 2'b01)
		oldest_level <= 1'b0;
		$display("t_reserved done");
	endtask : t_reserved
	// jumps, returns, wait, pause and two branch forms placed in an unequal branch slot
	task automatic t_slot_cti();
		logic [31:0] cti [9] = '{{OPC_JUMP, 26'h000_0000}, {OPC_SPECIAL, 5'd31, 15'h0000, FN_JUMP_REG},
			{OPC_COP0, 1'b1, 19'h0_0000, FN_EXC_RETURN}, {OPC_COP0, 1'b1, 18'h0_0000, 1'b1, FN_EXC_RETURN},
			{OPC_COP0, 1'b1, 19'h0_0000, FN_DBG_RETURN}, {OPC_COP0, 1'b1, 19'h0_0000, FN_WAIT},
			PAUSE_WORD, {OPC_REG_IMM_GROUP, 5'd0, 5'h10, 16'h0000}, {OPC_BR_UNEQUAL, 26'h000_0000}};
		release6 <= 1'b1;
		foreach (cti[i]) begin
			run_pair(bw(OPC_BR_UNEQUAL, 5'd1, 5'd2, 16'h0020), cti[i], 32'h0000_0001, '0);
			`CHK({c_seen, c_res2, c_red, c_ann}, 4'b1100)
		end
		run_pair(bw(OPC_BR_UNEQUAL, 5'd1, 5'd2, 16'h0020), '0, 32'h0000_0001, '0);
		`CHK({c_res2, c_red}, 2'b01)
		release6 <= 1'b0;
		$display("t_slot_cti done");
	endtask : t_slot_cti
	// enable low: a branch and its slot pass unseen, state stays idle
	task automatic t_hold();
		ce <= 1'b0;
		run_pair(bw(OPC_BR_UNEQUAL, 5'd1, 5'd2, 16'h0040), '0, 32'h0000_0003, '0);
		`CHK({c_seen, c_acc, c_red, c_ann, c_res2}, 5'b00000)
		ce <= 1'b1;
		run_pair(bw(OPC_BR_UNEQUAL, 5'd1, 5'd2, 16'h0040), '0, 32'h0000_0003, '0);
		`CHK({c_seen, c_red, c_rpc}, {2'b11, xt(16'h0040)})
		$display("t_hold done");
	endtask : t_hold
	task automatic test_done();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : test_done
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_unequal();
		t_likely();
		t_negative();
		t_reserved();
		t_slot_cti();
		t_hold();
		test_done();
	end
	// watchdog against a hung run
	initial begin
		repeat (3000) @(posedge clk);
		failures++;
		test_done();
	end
endmodule : tb
bind cblu_branch_unit cblu_sva chk (.clk(clk), .rst(rst), .ce(ce), .release6(release6),
	.oldest_level(oldest_level), .instr_valid(instr_valid), .instr(instr), .instr_pc(instr_pc),
	.source_reg_a_val(source_reg_a_val), .source_reg_b_val(source_reg_b_val),
	.branch_seen_q(branch_seen_q), .branch_taken_q(branch_taken_q),
	.branch_target_q(branch_target_q), .predict_taken_q(predict_taken_q),
	.predictor_access_q(predictor_access_q), .redirect_q(redirect_q),
	.redirect_pc_q(redirect_pc_q), .annul_slot_q(annul_slot_q), .reserved_instr_q(reserved_instr_q));
